// [verilog/fdss_regs.vh]
// Register offsets, field positions, reset values and limits of the fan drive source select block
`ifndef FDSS_REGS_VH
`define FDSS_REGS_VH

// ---------------------------------------------------------------
// Register word indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define FDSS_IDX_DUTY1       8'h30
`define FDSS_IDX_DUTY2       8'h31
`define FDSS_IDX_DUTY3       8'h32
`define FDSS_IDX_SUBST       8'h36
`define FDSS_IDX_CONFIG1     8'h40
`define FDSS_IDX_CHCFG1      8'h5C
`define FDSS_IDX_CHCFG2      8'h5D
`define FDSS_IDX_CHCFG3      8'h5E
`define FDSS_IDX_SPAN1       8'h5F
`define FDSS_IDX_SPAN2       8'h60
`define FDSS_IDX_SPAN3       8'h61
`define FDSS_IDX_STATUS      8'h80

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FDSS_ALT_BIT         3
`define FDSS_SRC_HI          7
`define FDSS_SRC_LO          5
`define FDSS_SUBST_BIT       4
`define FDSS_LOCK_BIT        0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FDSS_CHCFG_RST       8'h62
`define FDSS_SPAN_RST        8'hC4
`define FDSS_DUTY_RST        8'hFF
`define FDSS_SUBST_RST       8'h00
`define FDSS_CONFIG1_RST     8'h00

// ---------------------------------------------------------------
// Duty limits
// ---------------------------------------------------------------
`define FDSS_DUTY_FULL       8'hFF
`define FDSS_DUTY_OFF        8'h00

`endif

// [verilog/fdss_max_pick.v]
// Largest-of-N picker over packed duty values
`timescale 1ns/1ps
`default_nettype none

module fdss_max_pick #(
  parameter W = 8,
  parameter N = 4
) (
  // Packed candidates and enables
  input  wire [W*N-1:0] cand,
  input  wire [N-1:0]   use_mask,
  // Largest enabled candidate
  output reg  [W-1:0]   max_out
);

  integer i;

  // Disabled candidates count as zero so they never win
  always @* begin
    max_out = {W{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (use_mask[i] && (cand[i*W +: W] > max_out)) begin
        max_out = cand[i*W +: W];
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/fdss_chan_sel.v]
// One fan channel: decodes the source field and picks the duty to drive
`timescale 1ns/1ps
`default_nettype none
`include "fdss_regs.vh"

module fdss_chan_sel #(
  parameter W = 8
) (
  // Channel configuration
  input  wire [7:0]   chcfg,
  input  wire         force_alt,
  input  wire [W-1:0] manual_duty,
  // Duties computed per temperature source
  input  wire [W-1:0] duty_remote1,
  input  wire [W-1:0] duty_local,
  input  wire [W-1:0] duty_remote2,
  input  wire [4*W-1:0] duty_cpu,
  // Selected duty
  output wire [W-1:0] duty_sel
);

  wire [2:0]   src;
  wire         alternate_decode_select;
  reg  [6:0]   mask;
  reg  [W-1:0] direct;
  reg          use_max;
  wire [W-1:0] max_val;

  // [R14] substitute forces alt
  assign alternate_decode_select = chcfg[`FDSS_ALT_BIT] | force_alt;
  assign src = chcfg[`FDSS_SRC_HI:`FDSS_SRC_LO];

  // Mask order: local, remote1, remote2, cpu0..cpu3
  fdss_max_pick #(.W(W), .N(7)) u_max (
    .cand     ({duty_cpu, duty_remote2, duty_remote1, duty_local}),
    .use_mask (mask),
    .max_out  (max_val)
  );

  // Source decode; single sources also go through the picker for uniformity
  always @* begin
    mask    = 7'h00;
    direct  = {W{1'b0}};
    use_max = 1'b1;
    // [R6] alt bit selects decoding
    if (!alternate_decode_select) begin
      case (src)
        // [R1] single temperature sources
        3'h0: mask = 7'h02;
        3'h1: mask = 7'h01;
        3'h2: mask = 7'h04;
        // [R2] full speed and disabled
        3'h3: begin use_max = 1'b0; direct = {W{1'b1}}; end
        3'h4: begin use_max = 1'b0; direct = {W{1'b0}}; end
        // [R3] faster of local and remote 2
        3'h5: mask = 7'h05;
        // [R4] fastest of three channels
        3'h6: mask = 7'h07;
        // [R5] manual duty
        3'h7: begin use_max = 1'b0; direct = manual_duty; end
        default: begin use_max = 1'b0; direct = {W{1'b1}}; end
      endcase
    end else begin
      case (src)
        // [R7] cpu readings 0, 1, 3
        3'h0: mask = 7'h08;
        3'h1: mask = 7'h10;
        3'h3: mask = 7'h40;
        // [R9] fastest of four cpu readings
        3'h5: mask = 7'h78;
        // [R10] fastest of all zones
        3'h7: mask = 7'h7F;
        // [R8] reserved codes run full
        default: begin use_max = 1'b0; direct = {W{1'b1}}; end
      endcase
    end
  end

  // [R17] largest computed duty wins
  assign duty_sel = use_max ? max_val : direct;

endmodule

`default_nettype wire

// [verilog/fdss_top.v]
// APB register file and three-channel fan drive source selection
// Summary of operation
// [R1] Default codes 0-2 pick one temperature
// [R2] Code 3 full speed at reset, 4 off
// [R3] Code 5 faster of local, remote 2
// [R4] Code 6 fastest of three temperatures
// [R5] Code 7 manual, duty registers writable
// [R6] Channel bit 3 selects alternative decoding
// [R7] Alt codes 0,1,3 pick cpu readings
// [R8] Alt reserved codes 2,4,6 run full
// [R9] Alt code 5 fastest cpu reading
// [R10] Alt code 7 fastest of all zones
// [R11] Lock bit freezes channel configuration
// [R12] Lock bit freezes span registers
// [R13] Span registers reset to C4
// [R14] Substitute bit forces channel 1 alternative
// [R15] Host writes zero to substitute top bits
// [R16] Alt bit clear after reset
// [R17] Multi-source modes drive largest duty
`timescale 1ns/1ps
`default_nettype none
`include "fdss_regs.vh"

module fdss_top #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // APB slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  input  wire [3:0]   pstrb,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  // Duties computed per temperature source
  input  wire [W-1:0] duty_remote1,
  input  wire [W-1:0] duty_local,
  input  wire [W-1:0] duty_remote2,
  input  wire [W-1:0] cpu_thermal_reading_0,
  input  wire [W-1:0] cpu_thermal_reading_1,
  input  wire [W-1:0] cpu_thermal_reading_2,
  input  wire [W-1:0] cpu_thermal_reading_3,
  // Fan drive duties
  output reg  [W-1:0] fan_drive_output_1,
  output reg  [W-1:0] fan_drive_output_2,
  output reg  [W-1:0] fan_drive_output_3
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]   chcfg [0:2];
  reg  [7:0]   span  [0:2];
  reg  [7:0]   duty  [0:2];
  reg  [7:0]   subst;
  reg  [7:0]   config1;
  wire [W-1:0] sel   [0:2];
  wire         lock;
  wire [9:0]   widx;
  wire         setup_ok;
  wire         wr_en;
  wire         wr_lane0;
  reg  [7:0]   rd_byte;
  reg          rd_hit;

  assign lock     = config1[`FDSS_LOCK_BIT];
  assign widx     = paddr[11:2];
  // Access phase takes two cycles; pready registered at the first access edge, seen at the second
  assign setup_ok = psel & penable & ~pready;
  assign wr_en    = setup_ok & pwrite;
  assign wr_lane0 = pstrb[0];

  // Map an index to a valid register flag
  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = (idx == `FDSS_IDX_DUTY1) || (idx == `FDSS_IDX_DUTY2) ||
                  (idx == `FDSS_IDX_DUTY3) || (idx == `FDSS_IDX_SUBST) ||
                  (idx == `FDSS_IDX_CONFIG1) || (idx == `FDSS_IDX_STATUS) ||
                  ((idx >= `FDSS_IDX_CHCFG1) && (idx <= `FDSS_IDX_SPAN3));
    end
  endfunction

  // ---------------------------------------------------------------
  // Per-channel registers and selection
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      // Channel config, span and manual duty storage
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // [R16] alt clear, [R2] full speed code
          chcfg[g] <= `FDSS_CHCFG_RST;
          // [R13] span reset value
          span[g]  <= `FDSS_SPAN_RST;
          duty[g]  <= `FDSS_DUTY_RST;
        end else if (wr_en && wr_lane0) begin
          // [R11] lock blocks channel config
          if (!lock && widx == `FDSS_IDX_CHCFG1 + g) begin
            chcfg[g] <= pwdata[7:0];
          end
          // [R12] lock blocks span
          if (!lock && widx == `FDSS_IDX_SPAN1 + g) begin
            span[g] <= pwdata[7:0];
          end
          // [R5] manual duty only with code 7 and the alt bit clear in the channel config
          if (widx == `FDSS_IDX_DUTY1 + g &&
              chcfg[g][`FDSS_SRC_HI:`FDSS_SRC_LO] == 3'h7 && !chcfg[g][`FDSS_ALT_BIT]) begin
            duty[g] <= pwdata[7:0];
          end
        end
      end

      // [R14] substitute applies to channel 1 only
      fdss_chan_sel #(.W(W)) u_sel (
        .chcfg        (chcfg[g]),
        .force_alt    ((g == 0) ? subst[`FDSS_SUBST_BIT] : 1'b0),
        .manual_duty  (duty[g][W-1:0]),
        .duty_remote1 (duty_remote1),
        .duty_local   (duty_local),
        .duty_remote2 (duty_remote2),
        .duty_cpu     ({cpu_thermal_reading_3, cpu_thermal_reading_2,
                        cpu_thermal_reading_1, cpu_thermal_reading_0}),
        .duty_sel     (sel[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  // Substitute and lock; lock is sticky until reset so software cannot undo it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subst   <= `FDSS_SUBST_RST;
      config1 <= `FDSS_CONFIG1_RST;
    end else if (wr_en && wr_lane0) begin
      if (widx == `FDSS_IDX_SUBST) begin
        subst <= pwdata[7:0];
      end
      if (widx == `FDSS_IDX_CONFIG1) begin
        config1 <= {pwdata[7:1], pwdata[`FDSS_LOCK_BIT] | lock};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Status index shows the registered channel 1 fan drive output, one cycle behind its selected duty
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (widx)
      `FDSS_IDX_DUTY1:   rd_byte = duty[0];
      `FDSS_IDX_DUTY2:   rd_byte = duty[1];
      `FDSS_IDX_DUTY3:   rd_byte = duty[2];
      `FDSS_IDX_SUBST:   rd_byte = subst;
      `FDSS_IDX_CONFIG1: rd_byte = config1;
      `FDSS_IDX_CHCFG1:  rd_byte = chcfg[0];
      `FDSS_IDX_CHCFG2:  rd_byte = chcfg[1];
      `FDSS_IDX_CHCFG3:  rd_byte = chcfg[2];
      `FDSS_IDX_SPAN1:   rd_byte = span[0];
      `FDSS_IDX_SPAN2:   rd_byte = span[1];
      `FDSS_IDX_SPAN3:   rd_byte = span[2];
      `FDSS_IDX_STATUS:  rd_byte = fan_drive_output_1;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // APB handshake and outputs
  // ---------------------------------------------------------------
  // One wait state: pready rises the edge after the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (setup_ok) begin
      pready  <= 1'b1;
      pslverr <= ~is_mapped(widx);
      prdata  <= (pwrite || !rd_hit) ? 32'h00000000 : {24'h000000, rd_byte};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Registered fan duties; one cycle behind the sources
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_drive_output_1 <= {W{1'b1}};
      fan_drive_output_2 <= {W{1'b1}};
      fan_drive_output_3 <= {W{1'b1}};
    end else begin
      fan_drive_output_1 <= sel[0];
      fan_drive_output_2 <= sel[1];
      fan_drive_output_3 <= sel[2];
    end
  end

endmodule

`default_nettype wire

// [tb/fdss_props.sv]
// Port-level checks of the fan drive source select block
`timescale 1ns/1ps
`default_nettype none
`include "fdss_regs.vh"
module fdss_props #(
  parameter W = 8
) (
  // Bus side
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Fan side
  input wire logic [W-1:0] fan_drive_output_1,
  input wire logic [W-1:0] fan_drive_output_2,
  input wire logic [W-1:0] fan_drive_output_3
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] idx;
  logic       mapped;
  // Word index decode; anything outside this set must answer with an error
  assign idx = paddr[11:2];
  assign mapped = idx inside {`FDSS_IDX_DUTY1, `FDSS_IDX_DUTY2, `FDSS_IDX_DUTY3, `FDSS_IDX_SUBST,
    `FDSS_IDX_CONFIG1, [`FDSS_IDX_CHCFG1:`FDSS_IDX_SPAN3], `FDSS_IDX_STATUS};
  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    ##1 pready;
  endsequence
  property p_answer; s_req |-> s_ans; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err_unmapped; s_req ##0 !mapped |=> pslverr; endproperty
  property p_err_mapped; s_req ##0 mapped |=> !pslverr; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_status; s_req ##0 (!pwrite && idx == `FDSS_IDX_STATUS) |=> prdata[7:0] == $past(fan_drive_output_1);
  endproperty
  property p_reset_full; $rose(presetn) |-> (fan_drive_output_1 & fan_drive_output_2 & fan_drive_output_3) == 8'hFF;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access without error");
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access with error");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bytes not zero");
  a_status: assert property (p_status) else $error("status read differs from fan 1");
  a_reset_full: assert property (p_reset_full) else $error("fans not full after reset");
endmodule
bind fdss_top fdss_props #(.W(W)) u_fdss_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fan_drive_output_1(fan_drive_output_1), .fan_drive_output_2(fan_drive_output_2),
  .fan_drive_output_3(fan_drive_output_3));
`default_nettype wire

// [tb/fdss_fan_model.sv]
// Behavioural model of the three fans on the drive outputs
`timescale 1ns/1ps
`default_nettype none
module fdss_fan_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Drive duties
  input  wire logic [7:0] duty_1,
  input  wire logic [7:0] duty_2,
  input  wire logic [7:0] duty_3,
  // Fans turning
  output logic [2:0]      spinning
);
  // A fan only listens; it turns whenever its duty is above zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spinning <= 3'h0;
    end else begin
      spinning <= {duty_3 != 8'h00, duty_2 != 8'h00, duty_1 != 8'h00};
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the fan drive source select block
`timescale 1ns/1ps
`default_nettype none
`include "fdss_regs.vh"
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, er;
  logic [7:0]  t [7] = '{default: 8'h00};
  logic [7:0]  fo [3];
  logic [2:0]  spin;
  int          mismatches = 0, samples_checked = 0, cfg [3], man [3], d;
  always #50 pclk = ~pclk;
  fdss_top u_fdss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .duty_remote1(t[0]), .duty_local(t[1]), .duty_remote2(t[2]), .cpu_thermal_reading_0(t[3]),
    .cpu_thermal_reading_1(t[4]), .cpu_thermal_reading_2(t[5]), .cpu_thermal_reading_3(t[6]),
    .fan_drive_output_1(fo[0]), .fan_drive_output_2(fo[1]), .fan_drive_output_3(fo[2]));
  fdss_fan_model u_fdss_fan_model (.pclk(pclk), .presetn(presetn), .duty_1(fo[0]), .duty_2(fo[1]),
    .duty_3(fo[2]), .spinning(spin));
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(logic w, int idx, int wd);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= 12'(idx * 4);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [7:0] mxr(int lo, int hi);
    logic [7:0] m;
    m = 8'h00;
    for (int j = lo; j <= hi; j++) if (t[j] > m) m = t[j];
    return m;
  endfunction
  // Reference source decoding; fa forces the alternative table
  function automatic logic [7:0] exp_duty(int ch, bit fa);
    int c;
    c = cfg[ch] >> 5;
    if (cfg[ch][3] || fa) begin
      case (c)
        0, 1: return t[3 + c];
        3: return t[6];
        5: return mxr(3, 6);
        7: return mxr(0, 6);
        default: return 8'hFF;
      endcase
    end
    case (c)
      0, 1, 2: return t[c];
      3: return 8'hFF;
      4: return 8'h00;
      5: return mxr(1, 2);
      6: return mxr(0, 2);
      default: return 8'(man[ch]);
    endcase
  endfunction
  initial begin
    void'($urandom(32'h017C));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 3; i++) begin
      cfg[i] = 'h62;
      man[i] = 'hFF;
      apb(0, `FDSS_IDX_CHCFG1 + i, 0);
      cmp("chcfg", 32'h62, rd);
      apb(0, `FDSS_IDX_SPAN1 + i, 0);
      cmp("span", 32'hC4, rd);
      cmp("fan", 32'hFF, fo[i]);
    end
    // Every code under both decodings, duty writes tried in each mode
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 3; i++) begin
        cfg[i] = (k % 8) * 32 + (k / 8) * 8 + 2;
        apb(1, `FDSS_IDX_CHCFG1 + i, cfg[i]);
      end
      for (int i = 0; i < 3; i++) begin
        d = $urandom_range(255);
        apb(1, `FDSS_IDX_DUTY1 + i, d);
        if ((cfg[i] >> 3) == 28) man[i] = d;
        apb(0, `FDSS_IDX_DUTY1 + i, 0);
        cmp("duty", man[i], rd);
      end
      foreach (t[j]) t[j] <= 8'($urandom_range(255));
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 3; i++) cmp("fan", exp_duty(i, 0), fo[i]);
      // Fan model lags the drive by one edge; a zero duty must leave the fan stopped
      for (int i = 0; i < 3; i++) cmp("spin", exp_duty(i, 0) != 8'h00, spin[i]);
    end
    apb(0, `FDSS_IDX_STATUS, 0);
    cmp("status", exp_duty(0, 0), rd);
    // Substitute mode with the advised zero top bits
    cfg[0] = 'h02;
    apb(1, `FDSS_IDX_CHCFG1, cfg[0]);
    apb(1, `FDSS_IDX_SUBST, 'h10);
    repeat (3) @(posedge pclk);
    cmp("fan", exp_duty(0, 1), fo[0]);
    apb(0, 'h10, 0);
    cmp("err", 1, er);
    cmp("rd", 0, rd);
    // Span must take a write while unlocked, so the locked check below can trip
    apb(1, `FDSS_IDX_SPAN3, 'h3B);
    apb(0, `FDSS_IDX_SPAN3, 0);
    cmp("span", 32'h3B, rd);
    // Lock, then try to change configuration and span
    apb(1, `FDSS_IDX_CONFIG1, 1);
    apb(1, `FDSS_IDX_CHCFG2, 'hE0);
    apb(0, `FDSS_IDX_CHCFG2, 0);
    cmp("chcfg", cfg[1], rd);
    apb(1, `FDSS_IDX_SPAN3, 'h11);
    apb(0, `FDSS_IDX_SPAN3, 0);
    cmp("span", 32'h3B, rd);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 3; i++) cmp("fan", 32'hFF, fo[i]);
    report_and_stop();
  end
endmodule
`default_nettype wire
